// ==== hdl/efm_defs.vh ====
// constants for the external flash address map block
// assumes a 40 MHz ref_clk and a 16-bit wide parallel nor flash
`ifndef EFM_DEFS_VH
`define EFM_DEFS_VH

// top address bytes of the three windows
`define EFM_TOP_FIRST   8'hF8
`define EFM_TOP_BOOT    8'hF9
`define EFM_TOP_THIRD   8'hFA
// blocks 3..7 of a single large flash sit at identity addresses
`define EFM_TOP_ID_LO   8'h03
`define EFM_TOP_ID_HI   8'h07

// window indices
`define EFM_WIN_FIRST   2'h0
`define EFM_WIN_BOOT    2'h1
`define EFM_WIN_THIRD   2'h2

// boot fetch address: bootloader at start of block 0 (128 KB long)
`define EFM_BOOT_ADDR   32'hF9000000
`define EFM_BOOT_SIZE   32'h00020000
// reserved operating area, default and maximum 1 MB
`define EFM_RESV_START  32'hF9140000
`define EFM_RESV_UNIT   32'h00010000
`define EFM_RESV_MAX    5'h10

// probe reads this value when no device drives the bus
`define EFM_BLANK       16'hFFFF

// timing: flash access time, clock period, synchroniser latency
`define EFM_ACC_NS      90
`define EFM_CLK_NS      25
`define EFM_ACC_CYC     ((`EFM_ACC_NS + `EFM_CLK_NS - 1) / `EFM_CLK_NS)
`define EFM_SYNC_LAT    4
`define EFM_WAIT_CYC    (`EFM_ACC_CYC + `EFM_SYNC_LAT)

`endif

// ==== hdl/efm_sync.v ====
// three-stage synchroniser for a bus of pin inputs
// assumes the pins hold steady for several ref_clk cycles per change
`timescale 1ns/1ps
module efm_sync #(
  parameter W = 16
) (
  // clock and reset
  input  wire         ref_clk,
  input  wire         rst,
  // pins in, settled level out
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] level_out
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;

  // s1 is read by s2 alone; a change counts once s2 and s3 agree
  always @(posedge ref_clk) begin
    if (rst) begin
      s1_reg    <= {W{1'b0}};
      s2_reg    <= {W{1'b0}};
      s3_reg    <= {W{1'b0}};
      level_out <= {W{1'b0}};
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule // efm_sync

// ==== hdl/efm_top.v ====
// external flash address map: probe, boot fetch, decode, pattern load
// assumes one ref_clk domain and nor flash with a fixed access time
//
// Overview of operation
// [R1] three chip-select outputs: first window, boot window, third window
// [R2] each window spans at most 16 megabytes of flash
// [R3] two extension address lines reach past the per-window limit
// [R4] after power-up firmware is fetched from the boot window only
// [R5] every window is probed at power-up and presence is recorded
// [R6] no memory on the boot window means boot never completes
// [R7] block 0 at F9, 1 at FA, 2 at F8, blocks 3-7 identity
// [R8] a single flash up to 128 megabytes via selects plus extension lines
// [R9] an image lies wholly inside one window, never across two
// [R10] a stored pattern never crosses a 16-megabyte block boundary
// [R11] 128 KB bootloader expected at the very start of block 0
// [R12] reserved 1 MB region at F9140000 is never programmed
// [R13] reserved region defaults to 1 MB maximum, may be shrunk
// [R14] pattern load copies images from flash into internal memory
// [R15] extension pins serve flash addressing only, nothing else
// [R16] one select per access; none outside the mapped windows
`timescale 1ns/1ps
`include "efm_defs.vh"
module efm_top (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // configuration
  input  wire        cfg_single_flash,
  input  wire [4:0]  cfg_resv_64k,
  // single access request
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [31:0] req_addr,
  input  wire [15:0] req_wdata,
  output reg         req_ready,
  output reg         rsp_valid,
  output reg         rsp_err,
  output reg  [15:0] rsp_data,
  // pattern load request
  input  wire        load_start,
  input  wire [31:0] load_addr,
  input  wire [15:0] load_words,
  output reg         load_busy,
  output reg         load_done,
  output reg         load_err,
  output reg         mem_wr_en,
  output reg  [15:0] mem_wr_addr,
  output reg  [15:0] mem_wr_data,
  // boot status
  output reg  [2:0]  win_present,
  output reg         boot_done,
  output reg         boot_fail,
  output reg  [15:0] boot_word,
  // flash pins
  output reg         flash_select_first_n, // R1
  output reg         flash_select_boot_n,
  output reg         flash_select_third_n,
  output reg  [1:0]  flash_ext_addr,
  output reg  [22:0] flash_addr,
  output reg         flash_oe_n,
  output reg         flash_we_n,
  input  wire [15:0] flash_dq_in,
  output reg  [15:0] flash_dq_out,
  output reg         flash_dq_oe
);
  localparam [3:0] ST_PROBE = 4'h0;
  localparam [3:0] ST_PWAIT = 4'h1;
  localparam [3:0] ST_BOOT  = 4'h2;
  localparam [3:0] ST_BWAIT = 4'h3;
  localparam [3:0] ST_FAIL  = 4'h4;
  localparam [3:0] ST_IDLE  = 4'h5;
  localparam [3:0] ST_AWAIT = 4'h6;
  localparam [3:0] ST_LOAD  = 4'h7;
  localparam [3:0] ST_LWAIT = 4'h8;
  localparam [7:0] WAIT_CYC = `EFM_WAIT_CYC;
  localparam [7:0] DRV_CYC  = `EFM_ACC_CYC;

  reg  [3:0]  st_reg;
  reg  [7:0]  cnt_reg;
  reg  [1:0]  probe_reg;
  reg         wr_reg;
  reg  [31:0] cur_reg;
  reg  [15:0] left_reg;
  wire [15:0] dq_sync;

  efm_sync #(
    .W (16)
  ) u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pin_in    (flash_dq_in),
    .level_out (dq_sync)
  );

  // address decode shared by single accesses and pattern loads
  function [6:0] decode; // valid 6, ext 5:4, window 3:2, block 1:0
    input [31:0] a;
    input        single;
    reg   [7:0]  t;
    begin
      t      = a[31:24];
      decode = 7'h00;
      if (t == `EFM_TOP_BOOT) begin
        decode = {1'b1, 2'h0, `EFM_WIN_BOOT, 2'h0};  // R7
      end else if (t == `EFM_TOP_THIRD) begin
        decode = single ? {1'b1, 2'h0, `EFM_WIN_THIRD, 2'h1}
                        : {1'b1, 2'h0, `EFM_WIN_THIRD, 2'h1}; // R7
      end else if (t == `EFM_TOP_FIRST) begin
        decode = single ? {1'b1, 2'h1, `EFM_WIN_BOOT, 2'h2}
                        : {1'b1, 2'h0, `EFM_WIN_FIRST, 2'h2}; // R7
      end else if (single && t >= `EFM_TOP_ID_LO &&
                   t <= `EFM_TOP_ID_HI) begin
        // extension lines carry block bits 2:1, block bit 0 picks select
        decode = {1'b1, t[2:1], (t[0] ? `EFM_WIN_THIRD : `EFM_WIN_BOOT),
                  2'h3}; // R3 R8
      end
    end
  endfunction

  wire [6:0]  req_dec  = decode(req_addr, cfg_single_flash);
  wire [6:0]  load_dec = decode(load_addr, cfg_single_flash);
  wire [6:0]  cur_dec  = decode(cur_reg, cfg_single_flash);
  // a present window is needed; single flash presence is taken from the boot window alone
  wire req_here  = req_dec[6] & (cfg_single_flash ? win_present[1]
                                 : win_present[req_dec[3:2]]);
  wire load_here = load_dec[6] & (cfg_single_flash ? win_present[1]
                                  : win_present[load_dec[3:2]]);

  // reserved area size, clamped to its 1 MB maximum
  wire [4:0]  resv_n   = (cfg_resv_64k > `EFM_RESV_MAX) ? `EFM_RESV_MAX
                                                        : cfg_resv_64k;
  wire [31:0] resv_end = `EFM_RESV_START +
                         {11'h000, resv_n, 16'h0000}; // R13
  wire in_resv = req_addr >= `EFM_RESV_START && req_addr < resv_end;
  // the bootloader is kept from programming as well, losing it bricks boot
  wire in_boot = req_addr >= `EFM_BOOT_ADDR &&
                 req_addr < `EFM_BOOT_ADDR + `EFM_BOOT_SIZE; // R11
  wire wr_deny = req_write & (in_resv | in_boot); // R12

  // last byte of a load; same top byte means same block and window
  wire [31:0] load_last = load_addr + {15'h0000, load_words, 1'b0} -
                          32'h00000001;
  wire load_split = load_last[31:24] != load_addr[31:24]; // R9 R10

  always @(posedge ref_clk) begin
    if (rst) begin
      st_reg               <= ST_PROBE;
      cnt_reg              <= 8'h00;
      probe_reg            <= 2'h0;
      wr_reg               <= 1'b0;
      cur_reg              <= 32'h00000000;
      left_reg             <= 16'h0000;
      req_ready            <= 1'b0;
      rsp_valid            <= 1'b0;
      rsp_err              <= 1'b0;
      rsp_data             <= 16'h0000;
      load_busy            <= 1'b0;
      load_done            <= 1'b0;
      load_err             <= 1'b0;
      mem_wr_en            <= 1'b0;
      mem_wr_addr          <= 16'h0000;
      mem_wr_data          <= 16'h0000;
      win_present          <= 3'h0;
      boot_done            <= 1'b0;
      boot_fail            <= 1'b0;
      boot_word            <= 16'h0000;
      flash_select_first_n <= 1'b1;
      flash_select_boot_n  <= 1'b1;
      flash_select_third_n <= 1'b1;
      flash_ext_addr       <= 2'h0;
      flash_addr           <= 23'h000000;
      flash_oe_n           <= 1'b1;
      flash_we_n           <= 1'b1;
      flash_dq_out         <= 16'h0000;
      flash_dq_oe          <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      load_done <= 1'b0;
      load_err  <= 1'b0;
      mem_wr_en <= 1'b0;
      // index steps after each pulse, whatever state follows it
      if (mem_wr_en) begin
        mem_wr_addr <= mem_wr_addr + 16'h0001;
      end
      case (st_reg)
        ST_PROBE: begin
          // read word 0 of each window in turn
          flash_select_first_n <= probe_reg != `EFM_WIN_FIRST; // R5
          flash_select_boot_n  <= probe_reg != `EFM_WIN_BOOT;  // R5
          flash_select_third_n <= probe_reg != `EFM_WIN_THIRD; // R5
          flash_ext_addr       <= 2'h0; // R15
          flash_addr           <= 23'h000000;
          flash_oe_n           <= 1'b0;
          cnt_reg              <= 8'h00;
          st_reg               <= ST_PWAIT;
        end
        ST_PWAIT: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == WAIT_CYC) begin
            win_present[probe_reg] <= dq_sync != `EFM_BLANK; // R5
            flash_select_first_n   <= 1'b1;
            flash_select_boot_n    <= 1'b1;
            flash_select_third_n   <= 1'b1;
            flash_oe_n             <= 1'b1;
            if (probe_reg == `EFM_WIN_THIRD) begin
              st_reg <= ST_BOOT;
            end else begin
              probe_reg <= probe_reg + 2'h1;
              st_reg    <= ST_PROBE;
            end
          end
        end
        ST_BOOT: begin
          if (!win_present[1]) begin
            st_reg <= ST_FAIL; // R6
          end else begin
            // firmware comes from the boot window alone
            flash_select_boot_n <= 1'b0; // R4 R11
            flash_addr          <= 23'h000000;
            flash_oe_n          <= 1'b0;
            cnt_reg             <= 8'h00;
            st_reg              <= ST_BWAIT;
          end
        end
        ST_BWAIT: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == WAIT_CYC) begin
            boot_word           <= dq_sync; // R4
            boot_done           <= 1'b1;
            req_ready           <= 1'b1;
            flash_select_boot_n <= 1'b1;
            flash_oe_n          <= 1'b1;
            st_reg              <= ST_IDLE;
          end
        end
        ST_FAIL: begin
          boot_fail <= 1'b1; // R6
        end
        ST_IDLE: begin
          if (load_start) begin
            if (!load_here || load_split || load_words == 16'h0000) begin
              load_err <= 1'b1; // R9 R10
            end else begin
              cur_reg     <= load_addr;
              left_reg    <= load_words;
              mem_wr_addr <= 16'h0000;
              load_busy   <= 1'b1;
              req_ready   <= 1'b0;
              st_reg      <= ST_LOAD; // R14
            end
          end else if (req_valid) begin
            if (!req_here || wr_deny) begin
              rsp_valid <= 1'b1; // R16
              rsp_err   <= 1'b1;
            end else begin
              flash_select_first_n <= req_dec[3:2] != `EFM_WIN_FIRST; // R16
              flash_select_boot_n  <= req_dec[3:2] != `EFM_WIN_BOOT;  // R16
              flash_select_third_n <= req_dec[3:2] != `EFM_WIN_THIRD; // R16
              flash_ext_addr       <= req_dec[5:4]; // R3
              flash_addr           <= req_addr[23:1]; // R2
              flash_oe_n           <= req_write;
              flash_we_n           <= !req_write;
              flash_dq_out         <= req_wdata;
              flash_dq_oe          <= req_write;
              wr_reg               <= req_write;
              cnt_reg              <= 8'h00;
              req_ready            <= 1'b0;
              st_reg               <= ST_AWAIT;
            end
          end
        end
        ST_AWAIT: begin
          cnt_reg <= cnt_reg + 8'h01;
          // a write only needs the access time, a read also the sync
          if (cnt_reg == (wr_reg ? DRV_CYC : WAIT_CYC)) begin
            flash_select_first_n <= 1'b1;
            flash_select_boot_n  <= 1'b1;
            flash_select_third_n <= 1'b1;
            flash_oe_n           <= 1'b1;
            flash_we_n           <= 1'b1;
            flash_dq_oe          <= 1'b0;
            rsp_data             <= wr_reg ? 16'h0000 : dq_sync;
            rsp_err              <= 1'b0;
            rsp_valid            <= 1'b1;
            req_ready            <= 1'b1;
            st_reg               <= ST_IDLE;
          end
        end
        ST_LOAD: begin
          flash_select_first_n <= cur_dec[3:2] != `EFM_WIN_FIRST; // R16
          flash_select_boot_n  <= cur_dec[3:2] != `EFM_WIN_BOOT;  // R16
          flash_select_third_n <= cur_dec[3:2] != `EFM_WIN_THIRD; // R16
          flash_ext_addr       <= cur_dec[5:4]; // R8
          flash_addr           <= cur_reg[23:1];
          flash_oe_n           <= 1'b0;
          cnt_reg              <= 8'h00;
          st_reg               <= ST_LWAIT;
        end
        ST_LWAIT: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == WAIT_CYC) begin
            mem_wr_en            <= 1'b1; // R14
            mem_wr_data          <= dq_sync;
            flash_select_first_n <= 1'b1;
            flash_select_boot_n  <= 1'b1;
            flash_select_third_n <= 1'b1;
            flash_oe_n           <= 1'b1;
            cur_reg              <= cur_reg + 32'h00000002;
            left_reg             <= left_reg - 16'h0001;
            if (left_reg == 16'h0001) begin
              load_done <= 1'b1;
              load_busy <= 1'b0;
              req_ready <= 1'b1;
              st_reg    <= ST_IDLE;
            end else begin
              st_reg <= ST_LOAD;
            end
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // efm_top

// ==== test/efm_flash_model.sv ====
// behavioural nor flash on the three selects, 16-bit words
// assumes dq_in of the block is fed from flash_dq; data follows the address
`timescale 1ns/1ps
module efm_flash_model #(
  parameter DLY = 60
) (
  // which windows hold a device
  input  wire [2:0]  present,
  // flash pins
  input  wire        flash_select_first_n,
  input  wire        flash_select_boot_n,
  input  wire        flash_select_third_n,
  input  wire [1:0]  flash_ext_addr,
  input  wire [22:0] flash_addr,
  input  wire        flash_oe_n,
  input  wire        flash_we_n,
  input  wire [15:0] flash_dq_out,
  input  wire        flash_dq_oe,
  output wire [15:0] flash_dq,
  output reg  [7:0]  n_wr
);
  wire [1:0] code = !flash_select_first_n ? 2'h1 :
                    !flash_select_boot_n  ? 2'h2 :
                    !flash_select_third_n ? 2'h3 : 2'h0;
  wire       hit  = (code != 2'h0) && present[code - 2'h1];
  // top bit 0 so a present device never reads as blank
  wire [15:0] word = {1'b0, code, flash_ext_addr, flash_addr[10:0]};
  // released bus is pulled up, slow access time exercises the wait
  assign #DLY flash_dq = flash_dq_oe ? flash_dq_out :
                         (hit && !flash_oe_n) ? word : 16'hFFFF;
  initial n_wr = 8'h00;
  // selects settle in the same step as we_n, so look a moment later
  always @(negedge flash_we_n) begin
    #1;
    if (hit)
      n_wr <= n_wr + 8'h01;
  end
endmodule // efm_flash_model

// ==== test/efm_top_assertions.sv ====
// checker for efm_top: select decode, refusals, boot and load
// assumes it is bound to efm_top and sees only its ports
`timescale 1ns/1ps
module efm_top_assertions (
  // clock and reset
  input wire        ref_clk,
  input wire        rst,
  // watched ports
  input wire        cfg_single_flash,
  input wire [4:0]  cfg_resv_64k,
  input wire        req_valid,
  input wire        req_write,
  input wire [31:0] req_addr,
  input wire        req_ready,
  input wire        rsp_valid,
  input wire        rsp_err,
  input wire        load_start,
  input wire        load_busy,
  input wire        mem_wr_en,
  input wire        boot_done,
  input wire        boot_fail,
  input wire [2:0]  win_present,
  input wire        flash_select_first_n,
  input wire        flash_select_boot_n,
  input wire        flash_select_third_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire       take = req_ready && req_valid && !load_start;
  wire [7:0] top  = req_addr[31:24];
  wire [2:0] sel  = ~{flash_select_third_n, flash_select_boot_n,
                      flash_select_first_n};
  one_select_a: assert property ($countones(sel) <= 1)
    else $error("more than one select low");
  idle_sel_a: assert property (req_ready |-> sel == 3'h0)
    else $error("select low while idle");
  unmapped_a: assert property (take && !cfg_single_flash &&
    (top < 8'hF8 || top > 8'hFA) |=> rsp_valid && rsp_err)
    else $error("unmapped access not refused");
  boot_wr_a: assert property (take && req_write &&
    req_addr[31:17] == 15'h7C80 |=> rsp_valid && rsp_err)
    else $error("bootloader write not refused");
  resv_wr_a: assert property (take && req_write && cfg_resv_64k[4] &&
    req_addr >= 32'hF9140000 && req_addr < 32'hF9240000
    |=> rsp_valid && rsp_err)
    else $error("reserved write not refused");
  third_map_a: assert property (take && !req_write && top == 8'hFA &&
    !cfg_single_flash && win_present[2] |=> !flash_select_third_n)
    else $error("third window not selected");
  first_map_a: assert property (take && !req_write && top == 8'hF8 &&
    !cfg_single_flash && win_present[0] |=> !flash_select_first_n)
    else $error("first window not selected");
  boot_fail_a: assert property (boot_fail |-> !req_ready && !boot_done)
    else $error("service despite empty boot window");
  boot_ok_a: assert property ($rose(boot_done) |-> win_present[1])
    else $error("boot done without boot window");
  load_wr_a: assert property (mem_wr_en |-> $past(load_busy))
    else $error("memory write outside load");
  refuse_c: cover property (rsp_valid && rsp_err);
  load_c: cover property (mem_wr_en);
  fail_c: cover property (boot_fail);
endmodule // efm_top_assertions

bind efm_top efm_top_assertions efm_top_assertions_i (
  .ref_clk(ref_clk), .rst(rst), .cfg_single_flash(cfg_single_flash),
  .cfg_resv_64k(cfg_resv_64k), .req_valid(req_valid),
  .req_write(req_write), .req_addr(req_addr), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp_err(rsp_err), .load_start(load_start),
  .load_busy(load_busy), .mem_wr_en(mem_wr_en), .boot_done(boot_done),
  .boot_fail(boot_fail), .win_present(win_present),
  .flash_select_first_n(flash_select_first_n),
  .flash_select_boot_n(flash_select_boot_n),
  .flash_select_third_n(flash_select_third_n));

// ==== test/efm_top_tb.sv ====
// self-checking bench for efm_top with a nor flash model
// assumes ref_clk at 40 MHz; inputs change on the falling edge
`timescale 1ns/1ps
module efm_top_tb;
  reg         ref_clk, rst, cfg_single_flash, req_valid, req_write;
  reg         load_start;
  reg  [4:0]  cfg_resv_64k;
  reg  [31:0] req_addr, load_addr;
  reg  [15:0] load_words;
  reg  [2:0]  present;
  wire        req_ready, rsp_valid, rsp_err, load_busy, load_done;
  wire        load_err, mem_wr_en, boot_done, boot_fail, s0_n, s1_n, s2_n;
  wire        oe_n, we_n, dq_oe;
  wire [15:0] rsp_data, mem_wr_addr, mem_wr_data, boot_word, dq, dq_out;
  wire [2:0]  win_present;
  wire [1:0]  ext;
  wire [22:0] fa;
  wire [7:0]  n_wr;
  integer     n_mismatch, comparisons, cyc;
  efm_top efm_top_i (.ref_clk(ref_clk), .rst(rst),
    .cfg_single_flash(cfg_single_flash), .cfg_resv_64k(cfg_resv_64k),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(16'h5A5A), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_data(rsp_data), .load_start(load_start),
    .load_addr(load_addr), .load_words(load_words),
    .load_busy(load_busy), .load_done(load_done), .load_err(load_err),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .win_present(win_present),
    .boot_done(boot_done), .boot_fail(boot_fail), .boot_word(boot_word),
    .flash_select_first_n(s0_n), .flash_select_boot_n(s1_n),
    .flash_select_third_n(s2_n), .flash_ext_addr(ext), .flash_addr(fa),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_dq_in(dq),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe));
  efm_flash_model efm_flash_model_i (.present(present),
    .flash_select_first_n(s0_n), .flash_select_boot_n(s1_n),
    .flash_select_third_n(s2_n), .flash_ext_addr(ext), .flash_addr(fa),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .flash_dq(dq), .n_wr(n_wr));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function [15:0] pat(input [1:0] code, input [1:0] e, input [31:0] a);
    pat = {1'b0, code, e, a[11:1]};
  endfunction
  task check(input [95:0] what, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // bench cycle ceiling, well above the longest scenario
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end
  task idle;
    integer i;
    begin
      @(negedge ref_clk);
      for (i = 0; i < 40 && req_ready !== 1'b1; i = i + 1)
        @(negedge ref_clk);
    end
  endtask
  task do_reset(input [2:0] p);
    integer i;
    begin
      present = p;
      rst = 1'b1;
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      for (i = 0; i < 100 && req_ready !== 1'b1 && boot_fail !== 1'b1;
           i = i + 1)
        @(negedge ref_clk);
    end
  endtask
  task access(input w, input [31:0] a, input err, input [15:0] d);
    integer i;
    begin
      idle;
      req_write = w;
      req_addr = a;
      req_valid = 1'b1;
      @(negedge ref_clk) req_valid = 1'b0;
      for (i = 0; i < 40 && rsp_valid !== 1'b1; i = i + 1)
        @(negedge ref_clk);
      check("rsp_valid", rsp_valid, 1'b1);
      check("rsp_err", rsp_err, err);
      if (!err && !w)
        check("rsp_data", rsp_data, d);
    end
  endtask
  task load(input [31:0] a, input [15:0] n, input err, input [1:0] c);
    integer i, k;
    begin
      idle;
      load_addr = a;
      load_words = n;
      load_start = 1'b1;
      @(negedge ref_clk) load_start = 1'b0;
      check("load_busy", load_busy, !err);
      k = 0;
      for (i = 0; i < 400 && load_done !== 1'b1 && load_err !== 1'b1;
           i = i + 1) begin
        if (mem_wr_en === 1'b1) begin
          check("mem_wr_addr", mem_wr_addr, k);
          check("mem_wr_data", mem_wr_data, pat(c, 2'h0, a + 2 * k));
          k = k + 1;
        end
        @(negedge ref_clk);
      end
      // the last word is written in the cycle that load_done shows
      if (mem_wr_en === 1'b1) begin
        check("mem_wr_addr", mem_wr_addr, k);
        check("mem_wr_data", mem_wr_data, pat(c, 2'h0, a + 2 * k));
        k = k + 1;
      end
      check("load_done", load_done, !err);
      check("load_err", load_err, err);
      check("words", k, err ? 0 : n);
    end
  endtask
  task t_boot;
    begin
      check("win_present", win_present, 3'h7);
      check("boot_done", boot_done, 1'b1);
      check("boot_word", boot_word, pat(2'h2, 2'h0, 0));
    end
  endtask
  task t_map;
    begin
      access(0, 32'hF9000100, 0, pat(2'h2, 2'h0, 32'h100));
      access(0, 32'hFA000200, 0, pat(2'h3, 2'h0, 32'h200));
      access(0, 32'hF8000300, 0, pat(2'h1, 2'h0, 32'h300));
      access(0, 32'hFAFFFFFE, 0, pat(2'h3, 2'h0, 32'hFFE));
      access(0, 32'h10000000, 1, 16'h0);
      access(0, 32'h03000000, 1, 16'h0);
    end
  endtask
  task t_resv;
    reg [7:0] w0;
    begin
      cfg_resv_64k = 5'h10;
      w0 = n_wr;
      access(1, 32'hF9000010, 1, 16'h0);
      access(1, 32'hF9140000, 1, 16'h0);
      access(1, 32'hF923FFFE, 1, 16'h0);
      access(1, 32'hF9240000, 0, 16'h0);
      check("n_wr", n_wr, w0 + 8'h01);
      cfg_resv_64k = 5'h1F;
      access(1, 32'hF923FFFE, 1, 16'h0);
      cfg_resv_64k = 5'h01;
      access(1, 32'hF9150000, 0, 16'h0);
      cfg_resv_64k = 5'h10;
    end
  endtask
  task t_single;
    begin
      cfg_single_flash = 1'b1;
      access(0, 32'h03000010, 0, pat(2'h3, 2'h1, 32'h10));
      access(0, 32'h07000020, 0, pat(2'h3, 2'h3, 32'h20));
      access(0, 32'hF8000040, 0, pat(2'h2, 2'h1, 32'h40));
      access(0, 32'hFA000080, 0, pat(2'h3, 2'h0, 32'h80));
      access(0, 32'h08000000, 1, 16'h0);
      cfg_single_flash = 1'b0;
    end
  endtask
  task t_load;
    begin
      load(32'hF9240000, 16'h0004, 0, 2'h2);
      load(32'hF9FFFFFC, 16'h0004, 1, 2'h2);
      load(32'hFAFFFFFE, 16'h0002, 1, 2'h3);
      load(32'hFA000000, 16'h0000, 1, 2'h3);
      load(32'h20000000, 16'h0001, 1, 2'h0);
    end
  endtask
  task t_absent;
    begin
      do_reset(3'h3);
      check("win_present", win_present, 3'h3);
      access(0, 32'hFA000000, 1, 16'h0);
      do_reset(3'h5);
      check("boot_fail", boot_fail, 1'b1);
      check("req_ready", req_ready, 1'b0);
    end
  endtask
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    rst = 1'b1;
    cfg_single_flash = 1'b0;
    cfg_resv_64k = 5'h10;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 32'h0;
    load_start = 1'b0;
    load_addr = 32'h0;
    load_words = 16'h0;
    present = 3'h7;
    @(negedge ref_clk);
    do_reset(3'h7);
    t_boot;
    t_map;
    t_resv;
    t_single;
    t_load;
    t_absent;
    conclude;
  end
endmodule // efm_top_tb
